//--- hdl/app_pkg.sv
package app_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] APP_ADDR_PORT0 = 4'h0;
  localparam logic [3:0] APP_ADDR_PORT1 = 4'h1;
  localparam logic [3:0] APP_ADDR_PORT2 = 4'h2;
  localparam logic [3:0] APP_ADDR_CFG   = 4'h9;
  localparam logic [3:0] APP_ADDR_ISTAT = 4'ha;
  localparam logic [3:0] APP_ADDR_IMASK = 4'hb;
  localparam logic [3:0] APP_ADDR_CTRL  = 4'hc;
  // Configuration register fields
  localparam int APP_CFG_WIDTH_LO = 0;
  localparam int APP_CFG_WIDTH_HI = 1;
  localparam int APP_CFG_DAVAIL   = 2;
  localparam int APP_CFG_LSPACE   = 3;
  localparam int APP_CFG_DAPOL    = 4;
  localparam int APP_CFG_LSPOL    = 5;
  // Width codes
  localparam logic [1:0] APP_W_OFF = 2'h0;
  localparam logic [1:0] APP_W_8   = 2'h1;
  localparam logic [1:0] APP_W_16  = 2'h2;
  localparam logic [1:0] APP_W_24  = 2'h3;
  // Port 2 handshake bit positions
  localparam int APP_P2_LSPACE = 2;
  localparam int APP_P2_DAVAIL = 3;
  localparam int APP_P2_STB    = 4;
  localparam int APP_P2_OE     = 5;
  localparam int APP_P2_CS     = 6;
  // Interrupt status bits
  localparam int APP_IRQ_RD_DONE = 0;
  localparam int APP_IRQ_WR_DONE = 1;
  // Reset values
  localparam logic [7:0] APP_CFG_RST  = 8'h00;
  localparam logic [7:0] APP_GPIO_RST = 8'h00;
endpackage

//--- hdl/app_port.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module app_port
  import app_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [7:0]  i_p0,
  input  wire logic [7:0]  i_p1,
  input  wire logic [7:0]  i_p2,
  output logic      [7:0]  o_p0,
  output logic      [7:0]  o_p1,
  output logic      [7:0]  o_p2,
  output logic      [7:0]  o_p0_oe_n,
  output logic      [7:0]  o_p1_oe_n,
  output logic      [7:0]  o_p2_oe_n,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins idle high; the reset value matches so no false strobe follows
  logic [7:0] pin_raw  [3];
  logic [7:0] pin_s1_q [3];
  logic [7:0] pin_s2_q [3];
  logic [7:0] p2_sync;

  assign pin_raw[0] = i_p0;
  assign pin_raw[1] = i_p1;
  assign pin_raw[2] = i_p2;

  genvar s;
  generate
    for (s = 0; s < 3; s++)
    begin : gen_sync
      // Only the second stage is read; the first may still be settling
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          pin_s1_q[s] <= 8'hff;
          pin_s2_q[s] <= 8'hff;
        end
        else
        begin
          pin_s1_q[s] <= pin_raw[s];
          pin_s2_q[s] <= pin_s1_q[s];
        end
      end
    end
  endgenerate

  assign p2_sync = pin_s2_q[2];

  // ----------------------------------------------------------------
  // Configuration and handshake decode
  // ----------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] gpio_q [3];
  logic [1:0] width;
  logic       en;
  logic       wr_act, rd_act;
  logic       wr_act_q, rd_act_q;
  logic [2:0] port_used;

  assign width = cfg_q[APP_CFG_WIDTH_HI:APP_CFG_WIDTH_LO];
  assign en    = (width != APP_W_OFF);
  // Bytes in use
  // Handshake bits on port 2 stay handshake even at 24 bits
  always_comb
  begin
    port_used = 3'b000;
    unique case (width)
      APP_W_OFF: port_used = 3'b000;
      APP_W_8:   port_used = 3'b001;
      APP_W_16:  port_used = 3'b011;
      APP_W_24:  port_used = 3'b111;
    endcase
  end

  // Select gates strobes
  // Both ends of a transfer are seen two cycles late, after the synchroniser
  assign wr_act = en && !p2_sync[APP_P2_CS] && !p2_sync[APP_P2_STB];
  assign rd_act = en && !p2_sync[APP_P2_CS] && !p2_sync[APP_P2_OE];

  function automatic logic is_wr(input logic [3:0] a);
    is_wr = i_wr && (i_addr == a);
  endfunction

  function automatic logic is_rd(input logic [3:0] a);
    is_rd = i_rd && (i_addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Flag bits are not stored here; they are rebuilt from the pins on read
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_q <= APP_CFG_RST;
    else if (is_wr(APP_ADDR_CFG))
    begin
      cfg_q[APP_CFG_WIDTH_HI:APP_CFG_WIDTH_LO] <=
        i_wdata[APP_CFG_WIDTH_HI:APP_CFG_WIDTH_LO];
      cfg_q[APP_CFG_DAPOL] <= i_wdata[APP_CFG_DAPOL];
      cfg_q[APP_CFG_LSPOL] <= i_wdata[APP_CFG_LSPOL];
    end
  end

  // ----------------------------------------------------------------
  // Transfer tracking
  // ----------------------------------------------------------------
  // Delayed copies give the release edges that end each transfer
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  // ----------------------------------------------------------------
  // Output latches and data-avail flag
  // ----------------------------------------------------------------
  logic avail_q, space_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : gen_out
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          gpio_q[g] <= APP_GPIO_RST;
        else if (is_wr(4'(g)))
          gpio_q[g] <= i_wdata;
      end
    end
  endgenerate

  // Internal avail_q is the true "data waiting" state; set wins on overlap
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      avail_q <= 1'b0;
    else if (en && is_wr(APP_ADDR_PORT0))
      avail_q <= 1'b1;
    else if (rd_act)
      avail_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Input latches and latch-space flag
  // ----------------------------------------------------------------
  logic [7:0] in_q [3];

  generate
    for (g = 0; g < 3; g++)
    begin : gen_in
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          in_q[g] <= 8'h00;
        else if (wr_act && port_used[g])
          in_q[g] <= pin_s2_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      space_q <= 1'b1;
    else if (en && is_rd(APP_ADDR_PORT0))
      space_q <= 1'b1;
    else if (wr_act)
      space_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Handshake pins
  // ----------------------------------------------------------------
  logic avail_pin, space_pin;
  // Pin active high at polarity 0
  assign avail_pin = cfg_q[APP_CFG_DAPOL] ? !avail_q : avail_q;
  assign space_pin = cfg_q[APP_CFG_LSPOL] ? !space_q : space_q;

  logic [7:0] p2_out, p2_oe_n;
  logic [7:0] data_oe_n [3];
  logic       drive;
  // Drive while enable and select low
  assign drive = rd_act;

  // ----------------------------------------------------------------
  // Data pin drive enables
  // ----------------------------------------------------------------
  // Enables lag the pins by the two synchroniser stages, so the far
  // side must leave the data lines alone that long after a read
  generate
    for (g = 0; g < 3; g++)
    begin : gen_drive
      assign data_oe_n[g] = (drive && port_used[g]) ? 8'h00 : 8'hff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port 2 pin mux
  // ----------------------------------------------------------------
  // Mode overrides GPIO drive
  always_comb
  begin
    p2_out  = gpio_q[2];
    p2_oe_n = data_oe_n[2];
    if (en)
    begin
      p2_out[APP_P2_LSPACE]  = space_pin;
      p2_out[APP_P2_DAVAIL]  = avail_pin;
      p2_oe_n[APP_P2_LSPACE] = 1'b0;
      p2_oe_n[APP_P2_DAVAIL] = 1'b0;
      p2_oe_n[APP_P2_STB]    = 1'b1;
      p2_oe_n[APP_P2_OE]     = 1'b1;
      p2_oe_n[APP_P2_CS]     = 1'b1;
    end
  end

  // Handshake pins are combinational so they follow polarity changes at once
  assign o_p0      = gpio_q[0];
  assign o_p1      = gpio_q[1];
  assign o_p2      = p2_out;
  assign o_p0_oe_n = data_oe_n[0];
  assign o_p1_oe_n = data_oe_n[1];
  assign o_p2_oe_n = p2_oe_n;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [1:0] istat_q, imask_q;
  logic [1:0] ev;
  assign ev = {wr_act_q && !wr_act, rd_act_q && !rd_act};

  logic [1:0] istat_clr;
  assign istat_clr = is_wr(APP_ADDR_ISTAT) ? i_wdata[1:0] : 2'h0;

  // An event in the cycle of its own clear still sets, so none is lost
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      istat_q <= 2'h0;
    else
      istat_q <= (istat_q & ~istat_clr) | ev;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      imask_q <= 2'h0;
    else if (is_wr(APP_ADDR_IMASK))
      imask_q <= i_wdata[1:0];
  end

  assign o_irq = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;

  function automatic logic [7:0] port_rd(input int i);
    port_rd = port_used[i] ? in_q[i] : pin_s2_q[i];
  endfunction

  function automatic logic [7:0] cfg_view();
    cfg_view = {2'h0, cfg_q[APP_CFG_LSPOL], cfg_q[APP_CFG_DAPOL],
                !space_pin, !avail_pin, width};
  endfunction

  // Idle cycles return zero so a stale word is never taken for data
  always_comb
  begin
    rdata_d = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        APP_ADDR_PORT0: rdata_d = port_rd(0);
        APP_ADDR_PORT1: rdata_d = port_rd(1);
        APP_ADDR_PORT2: rdata_d = port_rd(2);
        APP_ADDR_CFG:   rdata_d = cfg_view();
        APP_ADDR_ISTAT: rdata_d = {6'h00, istat_q};
        APP_ADDR_IMASK: rdata_d = {6'h00, imask_q};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= 8'h00;
    else
      o_rdata <= rdata_d;
  end

endmodule

//--- verif/app_port_checker.sv
`timescale 1ns/1ns
module app_port_checker
  import app_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_p2,
  input wire logic [7:0] o_p2,
  input wire logic [7:0] o_p0_oe_n,
  input wire logic [7:0] o_p2_oe_n,
  input wire logic       o_irq
);
  logic       en_q;
  logic       dpol_q;
  logic       lpol_q;
  logic [2:0] cs_q;
  logic       idle;
  // Select high long enough that the synchroniser holds no stale request
  assign idle = &cs_q && i_p2[APP_P2_CS];
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {en_q, lpol_q, dpol_q} <= 3'h0;
    else if (i_wr && i_addr == APP_ADDR_CFG)
      {en_q, lpol_q, dpol_q} <= {|i_wdata[1:0], i_wdata[5:4]};
  end
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cs_q <= 3'h0;
    else
      cs_q <= {cs_q[1:0], i_p2[APP_P2_CS]};
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  mask_off_a: assert property (
    i_wr && i_addr == APP_ADDR_IMASK && i_wdata == 8'h00 |=> !o_irq)
    else $error("irq high with mask clear");
  hs_drive_a: assert property (
    en_q |-> o_p2_oe_n[3:2] == 2'b00) else $error("handshake out undriven");
  hs_input_a: assert property (
    o_p2_oe_n[6:4] == 3'b111) else $error("handshake input driven");
  cs_gate_a: assert property (
    i_p2[APP_P2_CS] [*4] |-> o_p0_oe_n == 8'hff)
    else $error("port driven without select");
  rd_drive_a: assert property (
    (en_q && !i_p2[APP_P2_CS] && !i_p2[APP_P2_OE]) [*4]
    |-> o_p0_oe_n == 8'h00) else $error("port not driven on read");
  avail_set_a: assert property (
    en_q && idle && i_wr && i_addr == APP_ADDR_PORT0
    |=> o_p2[APP_P2_DAVAIL] == !dpol_q) else $error("avail pin not set");
  space_set_a: assert property (
    en_q && idle && i_rd && i_addr == APP_ADDR_PORT0
    |=> o_p2[APP_P2_LSPACE] == !lpol_q) else $error("space pin not set");
  space_clr_a: assert property (
    (en_q && !i_p2[APP_P2_CS] && !i_p2[APP_P2_STB]) [*4]
    |-> o_p2[APP_P2_LSPACE] == lpol_q) else $error("space pin not clear");
endmodule
bind app_port app_port_checker chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_p2(i_p2), .o_p2(o_p2), .o_p0_oe_n(o_p0_oe_n),
  .o_p2_oe_n(o_p2_oe_n), .o_irq(o_irq));

//--- verif/app_ext_mcu.sv
`timescale 1ns/1ns
module app_ext_mcu
(
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_dev_p0,
  input  wire logic [7:0] i_dev_oe_n0,
  input  wire logic [7:0] i_dev_p1,
  input  wire logic [7:0] i_dev_oe_n1,
  input  wire logic [7:0] i_dev_p2,
  input  wire logic [7:0] i_dev_oe_n2,
  output logic      [7:0] o_pin0,
  output logic      [7:0] o_pin1,
  output logic      [7:0] o_pin2
);
  logic [15:0] dat_q = 16'h0000;
  logic       drv_q = 1'b0;
  logic [2:0] ctl_q = 3'h7;
  logic       tgl_q = 1'b0;
  // ----
  // Pin resolution
  // ----
  // Released lines flip every cycle so stale data never looks valid
  always @(posedge i_mclk) tgl_q <= ~tgl_q;
  always_comb
  begin
    o_pin0 = (i_dev_p0 & ~i_dev_oe_n0)
           | ((drv_q ? dat_q[7:0] : {8{tgl_q}}) & i_dev_oe_n0);
    o_pin1 = (i_dev_p1 & ~i_dev_oe_n1)
           | ((drv_q ? dat_q[15:8] : {8{tgl_q}}) & i_dev_oe_n1);
    o_pin2 = (i_dev_p2 & ~i_dev_oe_n2) | ({8{tgl_q}} & i_dev_oe_n2);
    o_pin2[6:4] = ctl_q;
  end
  task automatic ext_write(input logic [15:0] d, input logic cs);
    @(posedge i_mclk);
    dat_q <= d;
    drv_q <= 1'b1;
    ctl_q <= {cs, 2'b10};
    repeat (4) @(posedge i_mclk);
    ctl_q <= 3'h7;
    @(posedge i_mclk);
    drv_q <= 1'b0;
  endtask
  task automatic ext_read(output logic [15:0] d);
    @(posedge i_mclk);
    ctl_q <= 3'h1;
    repeat (5) @(posedge i_mclk);
    d = {o_pin1, o_pin0};
    ctl_q <= 3'h7;
  endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import app_pkg::*;
;
  logic       i_mclk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] o_rdata, o_p0, o_p1, o_p2, oe0, oe1, oe2, pin0, pin1, pin2;
  logic [15:0] v;
  logic       o_irq;
  int         fails = 0;
  int         compares = 0;
  app_port uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_p0(pin0), .i_p1(pin1), .i_p2(pin2), .o_p0(o_p0), .o_p1(o_p1),
    .o_p2(o_p2), .o_p0_oe_n(oe0), .o_p1_oe_n(oe1), .o_p2_oe_n(oe2),
    .o_irq(o_irq));
  app_ext_mcu mdl (.i_mclk(i_mclk),
    .i_dev_p0(o_p0), .i_dev_oe_n0(oe0), .i_dev_p1(o_p1),
    .i_dev_oe_n1(oe1), .i_dev_p2(o_p2), .i_dev_oe_n2(oe2),
    .o_pin0(pin0), .o_pin1(pin1), .o_pin2(pin2));
  // ----
  // Access tasks
  // ----
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #10;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e, input string n);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #10;
    chk(n, e, o_rdata & m);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #10;
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial forever #50 i_mclk = ~i_mclk;
  initial
  begin
    #500000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rdc(APP_ADDR_CFG, 8'h33, APP_CFG_RST, "cfg rst");
    for (int w = 0; w < 4; w++)
    begin
      wr(APP_ADDR_CFG, {2'b00, w[1:0], 2'b00, w[1:0]});
      rdc(APP_ADDR_CFG, 8'h33, {2'b00, w[1:0], 2'b00, w[1:0]}, "cfg");
    end
    rdc(4'hf, 8'hff, 8'h00, "unmapped");
    wr(APP_ADDR_IMASK, 8'h03);
    wr(APP_ADDR_CFG, {6'h00, APP_W_8});
    chk("p2 oe_n", 8'h70, oe2 & 8'h7c);
    wr(APP_ADDR_PORT0, 8'ha5);
    chk("avail pin", 8'h08, o_p2 & 8'h08);
    rdc(APP_ADDR_CFG, 8'h04, 8'h00, "avail flag");
    mdl.ext_read(v);
    chk("ext read", 8'ha5, v[7:0]);
    idle(4);
    chk("avail clr", 8'h00, o_p2 & 8'h08);
    chk("irq rd", 8'h01, {7'h00, o_irq});
    rdc(APP_ADDR_ISTAT, 8'hff, 8'h01, "istat rd");
    wr(APP_ADDR_ISTAT, 8'h01);
    chk("irq w1c", 8'h00, {7'h00, o_irq});
    mdl.ext_write(16'h003c, 1'b0);
    idle(4);
    chk("space clr", 8'h00, o_p2 & 8'h04);
    rdc(APP_ADDR_ISTAT, 8'hff, 8'h02, "istat wr");
    wr(APP_ADDR_ISTAT, 8'h02);
    rdc(APP_ADDR_PORT0, 8'hff, 8'h3c, "latch");
    chk("space set", 8'h04, o_p2 & 8'h04);
    wr(APP_ADDR_IMASK, 8'h00);
    mdl.ext_write(16'h0011, 1'b0);
    idle(4);
    chk("irq masked", 8'h00, {7'h00, o_irq});
    wr(APP_ADDR_IMASK, 8'h02);
    chk("irq unmask", 8'h01, {7'h00, o_irq});
    wr(APP_ADDR_ISTAT, 8'h02);
    mdl.ext_write(16'h0077, 1'b1);
    idle(4);
    rdc(APP_ADDR_ISTAT, 8'hff, 8'h00, "no select");
    rdc(APP_ADDR_PORT0, 8'hff, 8'h11, "held");
    wr(APP_ADDR_CFG, 8'h31);
    chk("pol pins", 8'h08, o_p2 & 8'h0c);
    rdc(APP_ADDR_CFG, 8'h0c, 8'h08, "pol flags");
    chk("space pol", 8'h00, o_p2 & 8'h04);
    wr(APP_ADDR_CFG, {6'h00, APP_W_16});
    wr(APP_ADDR_PORT1, 8'h5a);
    wr(APP_ADDR_PORT0, 8'hc3);
    mdl.ext_read(v);
    chk("read hi", 8'h5a, v[15:8]);
    chk("read lo", 8'hc3, v[7:0]);
    idle(4);
    mdl.ext_write(16'h9669, 1'b0);
    idle(4);
    rdc(APP_ADDR_PORT1, 8'hff, 8'h96, "latch hi");
    rdc(APP_ADDR_PORT0, 8'hff, 8'h69, "latch lo");
    chk("p1 idle oe_n", 8'hff, oe1);
    finish_test();
  end
endmodule
